/* sim/cgc_gate_check_tb.sv */
`timescale 1ns/1ps
module cgc_gate_check_tb;
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic req_valid_in = 1'b0;
    cgc_pkg::cgc_req_t req_in = '0;
    logic busy_out;
    logic res_valid_out;
    cgc_pkg::cgc_res_t res_out;
    cgc_pkg::cgc_req_t r;
    int err_count = 0;
    int n_tests = 0;

    // Core clock, 40 ns period
    always #20 clk_in = ~clk_in;

    cgc_gate_check i_cgc_gate_check (.clk_in(clk_in), .srst_in(srst_in),
        .req_valid_in(req_valid_in), .req_in(req_in), .busy_out(busy_out),
        .res_valid_out(res_valid_out), .res_out(res_out));

    // Compare and count
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // Verdict and end of run
    task automatic test_done();
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Builds a 16-byte gate image; legacy gates use the low half only
    function automatic logic [127:0] gate(input logic [63:0] ofs,
            input logic [3:0] ty, input logic [1:0] descriptor_privilege_level, input logic p,
            input logic [4:0] ut);
        gate = '0;
        gate[15:0] = ofs[15:0];
        gate[31:16] = 16'h0038;
        gate[36:32] = 5'h03;
        gate[43:40] = ty;
        gate[46:45] = descriptor_privilege_level;
        gate[47] = p;
        gate[63:48] = ofs[31:16];
        gate[95:64] = ofs[63:32];
        gate[108:104] = ut;
    endfunction

    // Legal legacy call to a more privileged nonconforming segment
    task automatic legacy();
        r = '0;
        r.is_call = 1'b1;
        r.gate_desc = gate(64'h1234_5678, cgc_pkg::TYPE_GATE32, 2'h3, 1'b1,
            5'h00);
        r.cur_cpl = 2'h3;
        r.cs_default32 = 1'b1;
        r.cs_base = 64'h1000;
    endtask

    // One request, bounded wait, latency and outcome flags
    task automatic run(input logic ok, input logic gp, input logic np);
        int k;
        @(negedge clk_in);
        req_in = r;
        req_valid_in = 1'b1;
        @(negedge clk_in);
        chk(busy_out, 1'b1);
        req_valid_in = 1'b0;
        k = 0;
        while (res_valid_out !== 1'b1 && k < 8) begin
            @(negedge clk_in);
            k++;
        end
        if (k == 8) begin
            err_count++;
            test_done();
        end
        chk(k, 1);
        chk({res_out.permit, res_out.gp_fault, res_out.np_fault}, {ok, gp, np});
    endtask

    // Entry address, push sizes, parameter units, pointer offset ignored
    task automatic t_legacy_call();
        legacy();
        r.ptr_offset = 32'hDEAD_BEEF;
        run(1'b1, 1'b0, 1'b0);
        chk(res_out.entry_addr, 64'h1234_6678);
        chk(res_out.push_bytes, cgc_pkg::PUSH_4);
        chk(res_out.param_count, 5'h03);
        chk(res_out.target_sel, 16'h0038);
        r.gate_desc[43:40] = cgc_pkg::TYPE_GATE16;
        r.gate_table = cgc_pkg::TBL_LOCAL;
        run(1'b1, 1'b0, 1'b0);
        chk(res_out.push_bytes, cgc_pkg::PUSH_2);
        chk(res_out.entry_addr, 64'h6678);
        chk(res_out.param_count, 5'h03);
    endtask

    // Table source and gate valid bit
    task automatic t_table_present();
        for (int t = 0; t < 4; t++) begin
            legacy();
            r.gate_table = t[1:0];
            run(t < 2, t >= 2, 1'b0);
        end
        legacy();
        r.gate_desc[47] = 1'b0;
        run(1'b0, 1'b0, 1'b1);
        chk(res_out.stack_switch, 1'b0);
        chk(res_out.fault_sel, 16'h0038);
    endtask

    // Caller and selector against gate privilege 2
    task automatic t_gate_priv();
        logic ok;
        for (int m = 0; m < 16; m++) begin
            legacy();
            r.gate_desc[46:45] = 2'h2;
            r.cs_conforming = 1'b1;
            r.cur_cpl = m[3:2];
            r.gate_rpl = m[1:0];
            ok = (m[3:2] <= 2) && (m[1:0] <= 2);
            run(ok, !ok, 1'b0);
            chk(res_out.new_cpl, r.cur_cpl);
            chk(res_out.stack_switch, 1'b0);
        end
    endtask

    // Every call/jump, conforming, caller and destination level pair
    task automatic t_levels();
        logic ok;
        logic sw;
        for (int m = 0; m < 64; m++) begin
            legacy();
            r.is_call = m[5];
            r.cs_conforming = m[4];
            r.cur_cpl = m[3:2];
            r.cs_dpl = m[1:0];
            ok = (m[4] || m[5]) ? m[1:0] <= m[3:2] : m[1:0] == m[3:2];
            sw = ok && !m[4] && m[1:0] < m[3:2];
            run(ok, !ok, 1'b0);
            chk(res_out.stack_switch, sw);
            chk(res_out.new_cpl, sw ? r.cs_dpl : r.cur_cpl);
            chk(res_out.param_count, sw ? 5'h03 : 5'h00);
        end
    endtask

    // Extended mode: 16-byte gate decode and its faults
    task automatic t_long();
        for (int m = 0; m < 6; m++) begin
            legacy();
            r.long_mode = 1'b1;
            r.cs_long = 1'b1;
            r.cs_default32 = 1'b0;
            r.gate_desc = gate(64'h0000_7FFF_1234_5678, cgc_pkg::TYPE_GATE32,
                2'h3, 1'b1, 5'h00);
            if (m == 1) r.gate_desc[95:64] = 32'h0000_8000;
            if (m == 2) r.gate_desc[108:104] = 5'h0C;
            if (m == 3) r.cs_default32 = 1'b1;
            if (m == 4) r.cs_long = 1'b0;
            if (m == 5) r.gate_desc[43:40] = cgc_pkg::TYPE_GATE16;
            run(m == 0, m != 0, 1'b0);
            if (m == 0) begin
                chk(res_out.entry_addr, 64'h0000_7FFF_1234_6678);
                chk(res_out.push_bytes, cgc_pkg::PUSH_8);
                chk(res_out.param_count, cgc_pkg::PCNT_NONE);
                chk(res_out.new_cpl, 2'h0);
                chk(res_out.stack_switch, 1'b1);
            end
            if (m == 1) chk(res_out.fault_sel, 16'h0000);
            if (m == 2) chk(res_out.gp_fault, 1'b1);
            if (m == 3) chk(res_out.fault_sel, 16'h0038);
            if (m == 5) chk(res_out.permit, 1'b0);
        end
    endtask

    // Main sequence
    initial begin
        repeat (6) @(negedge clk_in);
        srst_in = 1'b0;
        chk({busy_out, res_valid_out, res_out.permit, res_out.gp_fault,
            res_out.np_fault, res_out.stack_switch}, '0);
        chk(res_out.entry_addr, '0);
        t_legacy_call();
        t_table_present();
        t_gate_priv();
        t_levels();
        t_long();
        test_done();
    end
endmodule

/* src/cgc_gate_check.sv */
`timescale 1ns/1ps
module cgc_gate_check (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic req_valid_in,
    input wire cgc_pkg::cgc_req_t req_in,
    output logic busy_out,
    output logic res_valid_out,
    output cgc_pkg::cgc_res_t res_out
);

    cgc_pkg::cgc_state_t state;
    cgc_pkg::cgc_state_t next_state;
    cgc_pkg::cgc_req_t req;
    cgc_pkg::cgc_res_t res;
    cgc_pkg::cgc_res_t next_res;

    // Gate field decode
    wire [127:0] d = req.gate_desc;
    wire [15:0] g_sel = d[cgc_pkg::SEL_LSB +: 16];
    wire [4:0] g_pcnt = d[cgc_pkg::PCNT_LSB +: 5];
    wire [3:0] g_type = d[cgc_pkg::TYPE_LSB +: 4];
    wire [1:0] g_dpl = d[cgc_pkg::DPL_LSB +: 2];
    wire g_present = d[cgc_pkg::PRES_BIT];
    wire [4:0] g_utype = d[cgc_pkg::UTYPE_LSB +: 5];
    wire [31:0] ofs32 = {d[cgc_pkg::OFS_MID_LSB +: 16],
                         d[cgc_pkg::OFS_LO_LSB +: 16]};
    wire [63:0] ofs64 = {d[cgc_pkg::OFS_HI_LSB +: 32], ofs32};
    wire [15:0] ofs16 = d[cgc_pkg::OFS_LO_LSB +: 16];

    // Gate kind by mode
    wire is_g16 = !req.long_mode && g_type == cgc_pkg::TYPE_GATE16;
    wire is_g32 = !req.long_mode && g_type == cgc_pkg::TYPE_GATE32;
    wire is_g64 = req.long_mode && g_type == cgc_pkg::TYPE_GATE32;
    wire bad_type = !(is_g16 || is_g32 || is_g64);

    // Table and structural checks
    // Codes from the interrupt table upward are never gate sources
    wire bad_table = req.gate_table >= cgc_pkg::TBL_INTR;
    wire bad_upper = is_g64 && g_utype != cgc_pkg::UTYPE_ZERO;
    wire [16:0] sext_hi = ofs64[63:cgc_pkg::VA_BITS-1];
    wire noncanon = is_g64 && !(&sext_hi || ~|sext_hi);
    wire bad_cs_mode = is_g64 && !(req.cs_long && !req.cs_default32);

    // Privilege checks
    wire gate_priv_ok = req.cur_cpl <= g_dpl && req.gate_rpl <= g_dpl;
    wire conf_ok = req.cs_conforming && req.cs_dpl <= req.cur_cpl;
    wire nconf_call_ok = !req.cs_conforming && req.is_call &&
                         req.cs_dpl <= req.cur_cpl;
    wire nconf_jmp_ok = !req.cs_conforming && !req.is_call &&
                        req.cs_dpl == req.cur_cpl;
    wire dest_ok = conf_ok || nconf_call_ok || nconf_jmp_ok;

    // Fault priority: table, type and upper type, present, privilege, layout
    wire gp_gate = bad_table || bad_type || bad_upper;
    wire np = !gp_gate && !g_present;
    wire gp_priv = !gp_gate && g_present && (!gate_priv_ok || !dest_ok);
    wire gp_cs = !gp_gate && g_present && !gp_priv && (bad_cs_mode || noncanon);
    wire ok = !gp_gate && g_present && !gp_priv && !gp_cs;

    // Transfer outcome
    wire switch_stk = req.is_call && !req.cs_conforming &&
                      req.cs_dpl < req.cur_cpl;
    wire [63:0] g_ofs = is_g64 ? ofs64 :
                        is_g32 ? {32'h0000_0000, ofs32} :
                        {48'h0000_0000_0000, ofs16};
    wire [63:0] entry = req.cs_base + g_ofs;
    wire [3:0] push_w = is_g64 ? cgc_pkg::PUSH_8 :
                        is_g32 ? cgc_pkg::PUSH_4 : cgc_pkg::PUSH_2;
    wire [4:0] pcnt = (is_g64 || !switch_stk) ? cgc_pkg::PCNT_NONE
                                              : g_pcnt;

    // Result assembly; nothing changes unless permitted
    always_comb begin
        next_res = '0;
        next_res.permit = ok;
        next_res.gp_fault = gp_gate || gp_priv || gp_cs;
        next_res.np_fault = np;
        next_res.fault_sel = gp_cs && bad_cs_mode ? g_sel :
                             16'h0000;
        if (np) begin
            next_res.fault_sel = req.gate_desc[cgc_pkg::SEL_LSB +: 16];
        end
        if (ok) begin
            next_res.entry_addr = entry;
            next_res.new_cpl = switch_stk ? req.cs_dpl : req.cur_cpl;
            next_res.stack_switch = switch_stk;
            next_res.push_bytes = push_w;
            next_res.param_count = pcnt;
            next_res.target_sel = g_sel;
        end else begin
            next_res.new_cpl = req.cur_cpl;
        end
    end

    // Sequencer: capture, evaluate, present
    always_comb begin
        case (state)
            cgc_pkg::CGC_IDLE:
                next_state = req_valid_in ? cgc_pkg::CGC_EVAL
                                          : cgc_pkg::CGC_IDLE;
            cgc_pkg::CGC_EVAL: next_state = cgc_pkg::CGC_DONE;
            cgc_pkg::CGC_DONE: next_state = cgc_pkg::CGC_IDLE;
            default: next_state = cgc_pkg::CGC_IDLE;
        endcase
    end

    // Request capture; pointer offset is held but unused
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            req <= '0;
        end else if (state == cgc_pkg::CGC_IDLE && req_valid_in) begin
            req <= req_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state <= cgc_pkg::CGC_IDLE;
            res <= '0;
        end else begin
            state <= next_state;
            if (state == cgc_pkg::CGC_EVAL) begin
                res <= next_res;
            end
        end
    end

    assign busy_out = state != cgc_pkg::CGC_IDLE;
    assign res_valid_out = state == cgc_pkg::CGC_DONE;
    assign res_out = res;

    // Checks
    sequence s_taken;
        state == cgc_pkg::CGC_IDLE && req_valid_in;
    endsequence

    sequence s_answer;
        ##2 res_valid_out;
    endsequence

    a_answer_timing: assert property (@(posedge clk_in) disable iff (srst_in)
        s_taken |-> s_answer)
        else $error("answer not two cycles after request");
    a_intr_table: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && req.gate_table == cgc_pkg::TBL_INTR |-> !res.permit)
        else $error("interrupt table gate permitted");
    a_not_present: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && !g_present && !gp_gate |-> res.np_fault && !res.permit)
        else $error("absent gate without not-present fault");
    a_gate_priv: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && res.permit |-> req.cur_cpl <= g_dpl)
        else $error("caller less privileged than gate");
    a_rpl_priv: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && res.permit |-> req.gate_rpl <= g_dpl)
        else $error("selector level above gate level");
    a_jump_equal: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && res.permit && !req.is_call && !req.cs_conforming
        |-> req.cs_dpl == req.cur_cpl)
        else $error("jump changed nonconforming level");
    a_stack_switch: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && res.permit |->
        res.stack_switch == (res.new_cpl != req.cur_cpl))
        else $error("stack switch and level change disagree");
    a_conf_keep: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && req.cs_conforming |->
        res.new_cpl == req.cur_cpl && !res.stack_switch)
        else $error("conforming target changed level");
    a_long_push: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && res.permit && req.long_mode |->
        res.push_bytes == cgc_pkg::PUSH_8 && res.param_count == 5'h00)
        else $error("long gate push or copy wrong");
    a_long_cs: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && res.permit && req.long_mode |->
        req.cs_long && !req.cs_default32)
        else $error("long gate into non-long code");
    a_entry_addr: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && res.permit |-> res.entry_addr == req.cs_base + g_ofs)
        else $error("entry address mismatch");
    a_fault_hold: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && !res.permit |->
        res.new_cpl == req.cur_cpl && !res.stack_switch)
        else $error("faulted transfer changed state");

    // Three-step walk after a taken request
    sequence s_walk;
        state == cgc_pkg::CGC_EVAL ##1 state == cgc_pkg::CGC_DONE
        ##1 state == cgc_pkg::CGC_IDLE;
    endsequence

    a_state_walk: assert property (@(posedge clk_in) disable iff (srst_in)
        s_taken |=> s_walk)
        else $error("sequencer left its walk");

    a_reset_quiet: assert property (@(posedge clk_in)
        srst_in |=> !busy_out && !res_valid_out)
        else $error("outputs active after reset");

    a_valid_pulse: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out |=> !res_valid_out)
        else $error("result valid longer than one cycle");

    a_busy_ignore: assert property (@(posedge clk_in) disable iff (srst_in)
        busy_out |=> $stable(req))
        else $error("request taken while busy");

    a_result_hold: assert property (@(posedge clk_in) disable iff (srst_in)
        state != cgc_pkg::CGC_EVAL |=> $stable(res))
        else $error("result changed outside evaluation");

    a_table_fault: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && req.gate_table >= cgc_pkg::TBL_INTR |->
        res.gp_fault && !res.permit)
        else $error("bad table source not faulted");

    a_push_word: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && res.permit && is_g16 |->
        res.push_bytes == cgc_pkg::PUSH_2)
        else $error("16-bit gate push size wrong");

    a_push_dword: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && res.permit && is_g32 |->
        res.push_bytes == cgc_pkg::PUSH_4)
        else $error("32-bit gate push size wrong");

    a_absent_sel: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && res.np_fault |-> res.fault_sel == g_sel)
        else $error("not-present fault selector wrong");

    a_absent_block: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && !g_present |-> !res.permit)
        else $error("absent gate permitted");

    a_param_copy: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && res.permit && !req.long_mode && res.stack_switch
        |-> res.param_count == g_pcnt)
        else $error("parameter count not passed");

    a_param_none: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && res.permit && !res.stack_switch |->
        res.param_count == cgc_pkg::PCNT_NONE)
        else $error("parameters copied without switch");

    a_entry_word: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && res.permit && is_g16 |->
        res.entry_addr == req.cs_base + {48'h0000_0000_0000, ofs16})
        else $error("16-bit gate entry wrong");

    a_target_sel: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && res.permit |-> res.target_sel == g_sel)
        else $error("target selector wrong");

    a_caller_fault: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && !gp_gate && g_present && req.cur_cpl > g_dpl
        |-> res.gp_fault && !res.permit)
        else $error("weak caller not faulted");

    a_rpl_fault: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && !gp_gate && g_present && req.gate_rpl > g_dpl
        |-> res.gp_fault && !res.permit)
        else $error("weak selector not faulted");

    a_call_dest: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && res.permit && req.is_call && !req.cs_conforming
        |-> req.cs_dpl <= req.cur_cpl)
        else $error("call reached less privileged code");

    a_jump_fault: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && !gp_gate && g_present && !req.is_call &&
        !req.cs_conforming && req.cs_dpl != req.cur_cpl |->
        res.gp_fault)
        else $error("unequal jump not faulted");

    a_conf_dest: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && res.permit && req.cs_conforming |->
        req.cs_dpl <= req.cur_cpl)
        else $error("conforming target too weak");

    a_conf_fault: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && !gp_gate && g_present && req.cs_conforming &&
        req.cs_dpl > req.cur_cpl |-> res.gp_fault)
        else $error("weak conforming target not faulted");

    a_call_lower: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && res.permit && req.is_call && !req.cs_conforming &&
        req.cs_dpl < req.cur_cpl |->
        res.new_cpl == req.cs_dpl && res.stack_switch)
        else $error("inward call kept level");

    a_canon_fault: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && noncanon |-> res.gp_fault && !res.permit)
        else $error("noncanonical offset permitted");

    a_long_entry: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && res.permit && req.long_mode |->
        res.entry_addr == req.cs_base + ofs64)
        else $error("16-byte gate entry wrong");

    a_upper_fault: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && bad_upper |-> res.gp_fault && !res.permit)
        else $error("nonzero upper type permitted");

    a_cs_sel: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && g_present && !gp_gate && !gp_priv && bad_cs_mode
        |-> res.gp_fault && res.fault_sel == g_sel)
        else $error("code selector not reported");

    a_long_type: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && res.permit && req.long_mode |->
        g_type == cgc_pkg::TYPE_GATE32)
        else $error("other gate type in extended mode");

    a_long_word: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && req.long_mode && g_type == cgc_pkg::TYPE_GATE16
        |-> res.gp_fault && !res.permit)
        else $error("16-bit gate used in extended mode");

    a_one_outcome: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out |->
        $onehot({res.permit, res.gp_fault, res.np_fault}))
        else $error("outcome not exactly one");

    a_fault_clear: assert property (@(posedge clk_in) disable iff (srst_in)
        res_valid_out && !res.permit |->
        res.entry_addr == '0 && res.push_bytes == '0)
        else $error("faulted transfer carried target");

endmodule

/* src/cgc_pkg.sv */
package cgc_pkg;
    // Descriptor table selector
    localparam logic [1:0] TBL_GLOBAL = 2'h0;
    localparam logic [1:0] TBL_LOCAL = 2'h1;
    localparam logic [1:0] TBL_INTR = 2'h2;
    // Gate type codes (low nibble of the type field)
    localparam logic [3:0] TYPE_GATE16 = 4'h4;
    localparam logic [3:0] TYPE_GATE32 = 4'hC;
    // Gate low-word field positions
    localparam int OFS_LO_LSB = 0;
    localparam int SEL_LSB = 16;
    localparam int PCNT_LSB = 32;
    localparam int TYPE_LSB = 40;
    localparam int DPL_LSB = 45;
    localparam int PRES_BIT = 47;
    localparam int OFS_MID_LSB = 48;
    // Upper half: bytes 11:8 offset, bits 12:8 of top dword type
    localparam int OFS_HI_LSB = 64;
    localparam int UTYPE_LSB = 104;
    localparam logic [4:0] UTYPE_ZERO = 5'h00;
    // Canonical address width
    localparam int VA_BITS = 48;
    // Push unit sizes in bytes
    localparam logic [3:0] PUSH_2 = 4'h2;
    localparam logic [3:0] PUSH_4 = 4'h4;
    localparam logic [3:0] PUSH_8 = 4'h8;
    localparam logic [4:0] PCNT_NONE = 5'h00;

    // Request into the checker
    typedef struct packed {
        logic is_call;
        logic long_mode;
        logic [1:0] gate_table;
        logic [1:0] gate_rpl;
        logic [31:0] ptr_offset;
        logic [127:0] gate_desc;
        logic [1:0] cur_cpl;
        logic [1:0] cs_dpl;
        logic cs_conforming;
        logic cs_long;
        logic cs_default32;
        logic [63:0] cs_base;
    } cgc_req_t;

    // Result from the checker
    typedef struct packed {
        logic permit;
        logic gp_fault;
        logic np_fault;
        logic [15:0] fault_sel;
        logic [63:0] entry_addr;
        logic [1:0] new_cpl;
        logic stack_switch;
        logic [3:0] push_bytes;
        logic [4:0] param_count;
        logic [15:0] target_sel;
    } cgc_res_t;

    typedef enum logic [2:0] {
        CGC_IDLE = 3'h1,
        CGC_EVAL = 3'h2,
        CGC_DONE = 3'h4
    } cgc_state_t;
endpackage
